// File: design/serial_parallel_mode1_regs.sv
// mode 1 register bank, channel rams and address decode
//
// Contract
// - With page select clear and 32 channels, reads at 0 to 31 return the receive buffer byte and writes fill transmit buffer zero.
// - The page select bit (control bit 4) steers channel writes to transmit buffer one while reads stay on receive.
// - Flag and captured-byte registers at 0x24 to 0x27 are read-only and ignore writes.
// - Each path has a read/write mask at 0x28/0x29 and a compare byte at 0x2a/0x2b.
// - Each path has a read/write channel select at 0x2c/0x2d.
// - Writing one to control bit 6 clears both flag and captured-byte registers.
// - Control bit 6 returns to zero by itself once that clear is done.
// - Control bit 5 sizes all three rams: zero for 32 channels, one for 24 channels.
// - Control bit 3 picks static (0) or dynamic (1) generation for path two.
// - Control bit 2 picks static (0) or dynamic (1) generation for path one.
// - Control bit 1 must be one for path two to raise an interrupt.
// - Control bit 0 must be one for path one to raise an interrupt.
// - Reading a captured-byte register clears it.
// - Vector bits 1:0 mark the interrupting path and bits 7:2 hold the written value.
module serial_parallel_mode1_regs (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire serial_parallel_pkg::bus_in_s bus_in,
  output logic [7:0] rdata,
  output logic rdata_oe,
  output logic dtack_n,
  output logic irq_n,
  input wire serial_parallel_pkg::ram_wr_s rx_wr,
  input wire logic [4:0] tx_rd_chan,
  output logic [7:0] tx0_rd_data,
  output logic [7:0] tx1_rd_data,
  input wire serial_parallel_pkg::path_event_s path1_event,
  input wire serial_parallel_pkg::path_event_s path2_event,
  output serial_parallel_pkg::path_cfg_s path1_cfg,
  output serial_parallel_pkg::path_cfg_s path2_cfg,
  output logic ram_size_select,
  output logic [3:0] loop_output_config
);
  import serial_parallel_pkg::*;

  // ----------------------------------------
  // storage
  // ----------------------------------------
  logic [7:0] receive_buffer [RAM_DEPTH];
  logic [7:0] transmit_buffer_zero [RAM_DEPTH];
  logic [7:0] transmit_buffer_one [RAM_DEPTH];
  logic [7:0] main_control_ff;
  logic [3:0] loop_output_control_ff;
  logic [5:0] vector_high_ff;
  logic path1_vector_flag_ff, path2_vector_flag_ff;
  logic [7:0] path1_flags_ff, path2_flags_ff, path1_image_ff, path2_image_ff;
  logic [7:0] path1_mask_ff, path2_mask_ff, path1_compare_ff, path2_compare_ff;
  logic [7:0] path1_channel_ff, path2_channel_ff;
  logic [7:0] rdata_ff, tx0_rd_ff, tx1_rd_ff;
  logic busy_ff, dtack_ff;
  logic [7:0] nxt_rdata;

  // ----------------------------------------
  // access detect and decode
  // ----------------------------------------
  wire logic chip_sel = !bus_in.ds_n && (!bus_in.cs_n || !bus_in.iack_n);
  wire logic start = chip_sel && !busy_ff;
  wire logic vec_cycle = !bus_in.iack_n;
  wire logic rd = start && bus_in.read_not_write;
  wire logic wr = start && !bus_in.read_not_write && !vec_cycle;
  wire logic [5:0] a = bus_in.addr;
  wire logic ram_hit = !a[5];
  wire logic transmit_page_select = main_control_ff[BIT_PAGE];
  wire logic chan_ok = !main_control_ff[BIT_RAM_SIZE] || (a[4:0] < CHANNELS_SHORT);
  wire logic wr_tx0 = wr && ram_hit && chan_ok && !transmit_page_select;
  wire logic wr_tx1 = wr && ram_hit && chan_ok && transmit_page_select;
  wire logic wr_main = wr && (a == ADDR_MAIN_CONTROL);
  wire logic wr_loop = wr && (a == ADDR_LOOP_OUTPUT);
  wire logic wr_vec = wr && (a == ADDR_VECTOR);
  wire logic wr_p1_mask = wr && (a == ADDR_P1_MASK);
  wire logic wr_p2_mask = wr && (a == ADDR_P2_MASK);
  wire logic wr_p1_cmp = wr && (a == ADDR_P1_COMPARE);
  wire logic wr_p2_cmp = wr && (a == ADDR_P2_COMPARE);
  wire logic wr_p1_chan = wr && (a == ADDR_P1_CHANNEL);
  wire logic wr_p2_chan = wr && (a == ADDR_P2_CHANNEL);
  wire logic rd_p1_flags = rd && !vec_cycle && (a == ADDR_P1_FLAGS);
  wire logic rd_p2_flags = rd && !vec_cycle && (a == ADDR_P2_FLAGS);
  wire logic rd_p1_image = rd && !vec_cycle && (a == ADDR_P1_IMAGE);
  wire logic rd_p2_image = rd && !vec_cycle && (a == ADDR_P2_IMAGE);
  wire logic clear_all = main_control_ff[BIT_CLEAR];
  wire logic p1_take = path1_event.hit && main_control_ff[BIT_P1_ENABLE];
  wire logic p2_take = path2_event.hit && main_control_ff[BIT_P2_ENABLE];
  wire logic [7:0] vector_word = {vector_high_ff, path2_vector_flag_ff, path1_vector_flag_ff};
  wire logic [7:0] rx_probe = receive_buffer[a[4:0]];
  wire logic [7:0] tx0_probe = transmit_buffer_zero[a[4:0]];
  wire logic [7:0] tx1_probe = transmit_buffer_one[a[4:0]];

  // read mux; unmapped and short-mode channels read zero
  always_comb begin
    nxt_rdata = RST_BYTE;
    if (vec_cycle) begin
      nxt_rdata = vector_word;
    end else if (ram_hit) begin
      nxt_rdata = chan_ok ? rx_probe : RST_BYTE;
    end else if (a == ADDR_MAIN_CONTROL) begin
      nxt_rdata = main_control_ff;
    end else if (a == ADDR_LOOP_OUTPUT) begin
      nxt_rdata = {4'h0, loop_output_control_ff};
    end else if (a == ADDR_VECTOR) begin
      nxt_rdata = vector_word;
    end else if (a == ADDR_P1_FLAGS) begin
      nxt_rdata = path1_flags_ff;
    end else if (a == ADDR_P2_FLAGS) begin
      nxt_rdata = path2_flags_ff;
    end else if (a == ADDR_P1_IMAGE) begin
      nxt_rdata = path1_image_ff;
    end else if (a == ADDR_P2_IMAGE) begin
      nxt_rdata = path2_image_ff;
    end else if (a == ADDR_P1_MASK) begin
      nxt_rdata = path1_mask_ff;
    end else if (a == ADDR_P2_MASK) begin
      nxt_rdata = path2_mask_ff;
    end else if (a == ADDR_P1_COMPARE) begin
      nxt_rdata = path1_compare_ff;
    end else if (a == ADDR_P2_COMPARE) begin
      nxt_rdata = path2_compare_ff;
    end else if (a == ADDR_P1_CHANNEL) begin
      nxt_rdata = path1_channel_ff;
    end else if (a == ADDR_P2_CHANNEL) begin
      nxt_rdata = path2_channel_ff;
    end
  end

  // ----------------------------------------
  // bus handshake
  // ----------------------------------------
  // one access per strobe; acknowledge held until strobe drops
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      busy_ff <= 1'b0;
      dtack_ff <= 1'b0;
      rdata_ff <= RST_BYTE;
    end else begin
      busy_ff <= chip_sel;
      dtack_ff <= chip_sel;
      if (rd) begin
        rdata_ff <= nxt_rdata;
      end
    end
  end

  assign dtack_n = !(dtack_ff && chip_sel);
  assign rdata_oe = dtack_ff && chip_sel && bus_in.read_not_write;
  assign rdata = rdata_ff;

  // ----------------------------------------
  // channel rams
  // ----------------------------------------
  // serial side fills receive, bus fills transmit pages; no reset on data
  always_ff @(posedge sys_clk) begin
    if (rx_wr.en) begin
      receive_buffer[rx_wr.chan] <= rx_wr.data;
    end
    if (wr_tx0) begin
      transmit_buffer_zero[a[4:0]] <= bus_in.wdata;
    end
    if (wr_tx1) begin
      transmit_buffer_one[a[4:0]] <= bus_in.wdata;
    end
    tx0_rd_ff <= transmit_buffer_zero[tx_rd_chan];
    tx1_rd_ff <= transmit_buffer_one[tx_rd_chan];
  end

  assign tx0_rd_data = tx0_rd_ff;
  assign tx1_rd_data = tx1_rd_ff;

  // ----------------------------------------
  // control and configuration registers
  // ----------------------------------------
  // clear bit lives one cycle, then drops by itself
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      main_control_ff <= RST_BYTE;
      loop_output_control_ff <= RST_NIBBLE;
      vector_high_ff <= RST_VECTOR_HIGH;
    end else begin
      if (wr_main) begin
        main_control_ff <= bus_in.wdata & MAIN_CONTROL_WMASK;
      end else if (clear_all) begin
        main_control_ff[BIT_CLEAR] <= 1'b0;
      end
      if (wr_loop) begin
        loop_output_control_ff <= bus_in.wdata[3:0];
      end
      if (wr_vec) begin
        vector_high_ff <= bus_in.wdata[7:2];
      end
    end
  end

  // per-path set-up registers; all other write addresses fall through
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      path1_mask_ff <= RST_BYTE;
      path2_mask_ff <= RST_BYTE;
      path1_compare_ff <= RST_BYTE;
      path2_compare_ff <= RST_BYTE;
      path1_channel_ff <= RST_BYTE;
      path2_channel_ff <= RST_BYTE;
    end else begin
      if (wr_p1_mask) path1_mask_ff <= bus_in.wdata;
      if (wr_p2_mask) path2_mask_ff <= bus_in.wdata;
      if (wr_p1_cmp) path1_compare_ff <= bus_in.wdata;
      if (wr_p2_cmp) path2_compare_ff <= bus_in.wdata;
      if (wr_p1_chan) path1_channel_ff <= bus_in.wdata;
      if (wr_p2_chan) path2_channel_ff <= bus_in.wdata;
    end
  end

  // ----------------------------------------
  // flags, captured bytes, vector marks
  // ----------------------------------------
  // an arriving event beats a clear in the same cycle; no bus write path here
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      path1_flags_ff <= RST_BYTE;
      path2_flags_ff <= RST_BYTE;
      path1_image_ff <= RST_BYTE;
      path2_image_ff <= RST_BYTE;
      path1_vector_flag_ff <= 1'b0;
      path2_vector_flag_ff <= 1'b0;
    end else begin
      if (p1_take) begin
        path1_flags_ff <= path1_flags_ff | path1_event.flags;
        path1_vector_flag_ff <= 1'b1;
      end else if (clear_all || rd_p1_flags) begin
        path1_flags_ff <= RST_BYTE;
        path1_vector_flag_ff <= 1'b0;
      end
      if (p2_take) begin
        path2_flags_ff <= path2_flags_ff | path2_event.flags;
        path2_vector_flag_ff <= 1'b1;
      end else if (clear_all || rd_p2_flags) begin
        path2_flags_ff <= RST_BYTE;
        path2_vector_flag_ff <= 1'b0;
      end
      if (p1_take) begin
        path1_image_ff <= path1_event.image;
      end else if (clear_all || rd_p1_image) begin
        path1_image_ff <= RST_BYTE;
      end
      if (p2_take) begin
        path2_image_ff <= path2_event.image;
      end else if (clear_all || rd_p2_image) begin
        path2_image_ff <= RST_BYTE;
      end
    end
  end

  // ----------------------------------------
  // configuration outputs
  // ----------------------------------------
  assign ram_size_select = main_control_ff[BIT_RAM_SIZE];
  assign loop_output_config = loop_output_control_ff;
  assign path1_cfg = {main_control_ff[BIT_P1_ENABLE], main_control_ff[BIT_P1_KIND],
                      path1_mask_ff, path1_compare_ff, path1_channel_ff};
  assign path2_cfg = {main_control_ff[BIT_P2_ENABLE], main_control_ff[BIT_P2_KIND],
                      path2_mask_ff, path2_compare_ff, path2_channel_ff};
  assign irq_n = !(path1_vector_flag_ff || path2_vector_flag_ff);

  // ----------------------------------------
  // checks
  // ----------------------------------------
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);

  sequence s_clear_write;
    wr_main && bus_in.wdata[BIT_CLEAR];
  endsequence
  sequence s_clear_done;
    clear_all ##1 !main_control_ff[BIT_CLEAR];
  endsequence

  property p_rx_read;
    rd && !vec_cycle && ram_hit && chan_ok |=> rdata_ff == $past(rx_probe);
  endproperty
  a_rx_read: assert property (p_rx_read) else $error("channel read not from receive buffer");
  property p_page_one;
    wr && ram_hit && chan_ok && transmit_page_select ##1 $stable(bus_in.addr) |-> tx1_probe == $past(bus_in.wdata);
  endproperty
  a_page_one: assert property (p_page_one) else $error("page one write missed");
  property p_flags_ro;
    wr && (a == ADDR_P1_FLAGS) && !p1_take && !clear_all |=> $stable(path1_flags_ff);
  endproperty
  a_flags_ro: assert property (p_flags_ro) else $error("flag register took a write");
  property p_mask_rw;
    wr_p1_mask |=> path1_cfg.mask == $past(bus_in.wdata);
  endproperty
  a_mask_rw: assert property (p_mask_rw) else $error("mask write lost");
  property p_chan_rw;
    wr && (a == ADDR_P2_CHANNEL) |=> path2_cfg.channel == $past(bus_in.wdata);
  endproperty
  a_chan_rw: assert property (p_chan_rw) else $error("channel select write lost");
  property p_clear;
    s_clear_write ##1 (!p1_take && !p2_take) |=> path1_image_ff == 8'h00 && path2_flags_ff == 8'h00;
  endproperty
  a_clear: assert property (p_clear) else $error("clear left state");
  property p_self_clear;
    s_clear_write ##1 !wr_main |-> s_clear_done;
  endproperty
  a_self_clear: assert property (p_self_clear) else $error("clear bit stuck");
  property p_short_ram;
    wr && ram_hit && ram_size_select && a[4:0] >= CHANNELS_SHORT ##1 $stable(bus_in.addr) |-> $stable(tx0_probe);
  endproperty
  a_short_ram: assert property (p_short_ram) else $error("write past channel 23");
  property p_kind2;
    wr_main |=> path2_cfg.kind == $past(bus_in.wdata[BIT_P2_KIND]);
  endproperty
  a_kind2: assert property (p_kind2) else $error("path two kind wrong");
  property p_gate1;
    path1_event.hit && !path1_cfg.enable && !path1_vector_flag_ff |=> !path1_vector_flag_ff;
  endproperty
  a_gate1: assert property (p_gate1) else $error("disabled path raised request");
  property p_image_rd;
    rd_p2_image && !p2_take |=> path2_image_ff == 8'h00;
  endproperty
  a_image_rd: assert property (p_image_rd) else $error("image not cleared by read");
  property p_vector;
    rd && vec_cycle && !irq_n |=> rdata_ff[1:0] != 2'b00;
  endproperty
  a_vector: assert property (p_vector) else $error("vector mark missing");
endmodule // serial_parallel_mode1_regs

// File: pkg/serial_parallel_pkg.sv
// shared constants and carrier types for the mode 1 register bank
package serial_parallel_pkg;
  // ----------------------------------------
  // address map
  // ----------------------------------------
  localparam logic [5:0] ADDR_MAIN_CONTROL = 6'h20;
  localparam logic [5:0] ADDR_LOOP_OUTPUT = 6'h21;
  localparam logic [5:0] ADDR_VECTOR = 6'h22;
  localparam logic [5:0] ADDR_P1_FLAGS = 6'h24;
  localparam logic [5:0] ADDR_P2_FLAGS = 6'h25;
  localparam logic [5:0] ADDR_P1_IMAGE = 6'h26;
  localparam logic [5:0] ADDR_P2_IMAGE = 6'h27;
  localparam logic [5:0] ADDR_P1_MASK = 6'h28;
  localparam logic [5:0] ADDR_P2_MASK = 6'h29;
  localparam logic [5:0] ADDR_P1_COMPARE = 6'h2a;
  localparam logic [5:0] ADDR_P2_COMPARE = 6'h2b;
  localparam logic [5:0] ADDR_P1_CHANNEL = 6'h2c;
  localparam logic [5:0] ADDR_P2_CHANNEL = 6'h2d;
  // ----------------------------------------
  // main control field positions
  // ----------------------------------------
  localparam int BIT_P1_ENABLE = 0;
  localparam int BIT_P2_ENABLE = 1;
  localparam int BIT_P1_KIND = 2;
  localparam int BIT_P2_KIND = 3;
  localparam int BIT_PAGE = 4;
  localparam int BIT_RAM_SIZE = 5;
  localparam int BIT_CLEAR = 6;
  localparam logic [7:0] MAIN_CONTROL_WMASK = 8'h7f;
  localparam logic [4:0] CHANNELS_SHORT = 5'h18;
  localparam int RAM_DEPTH = 32;
  // ----------------------------------------
  // reset values
  // ----------------------------------------
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [3:0] RST_NIBBLE = 4'h0;
  localparam logic [5:0] RST_VECTOR_HIGH = 6'h00;
  // ----------------------------------------
  // carriers
  // ----------------------------------------
  typedef struct packed {
    logic cs_n;
    logic ds_n;
    logic read_not_write;
    logic iack_n;
    logic [5:0] addr;
    logic [7:0] wdata;
  } bus_in_s;
  typedef struct packed {
    logic hit;
    logic [7:0] flags;
    logic [7:0] image;
  } path_event_s;
  typedef struct packed {
    logic enable;
    logic kind;
    logic [7:0] mask;
    logic [7:0] compare;
    logic [7:0] channel;
  } path_cfg_s;
  typedef struct packed {
    logic en;
    logic [4:0] chan;
    logic [7:0] data;
  } ram_wr_s;
endpackage : serial_parallel_pkg

// File: verification/serial_parallel_host_model.sv
// host bus master model driving the mode 1 register bank
module serial_parallel_host_model (
  input wire logic sys_clk,
  input wire logic dtack_n,
  input wire logic [7:0] rdata,
  input wire logic rdata_oe,
  output serial_parallel_pkg::bus_in_s bus_in
);
  timeunit 1ns;
  timeprecision 1ps;
  import serial_parallel_pkg::*;
  // idle bus: strobes high, address and data far from the last cycle
  initial begin
    bus_in = '{cs_n: 1'b1, ds_n: 1'b1, read_not_write: 1'b1, iack_n: 1'b1, addr: 6'h3f, wdata: 8'h00};
  end
  // one strobe, held until acknowledge is seen at a falling edge or 16 falling edges pass without it
  task automatic access(input logic iack, input logic rnw, input logic [5:0] addr, input logic [7:0] wdata,
                        output logic [7:0] data, output logic ok);
    int i;
    ok = 1'b0;
    data = 8'hxx;
    @(negedge sys_clk);
    bus_in = '{cs_n: iack, ds_n: 1'b0, read_not_write: rnw, iack_n: !iack, addr: addr, wdata: wdata};
    for (i = 0; i < 16 && !ok; i++) begin
      @(negedge sys_clk);
      if (dtack_n === 1'b0) begin
        ok = 1'b1;
      end
    end
    @(posedge sys_clk);
    if (ok && rnw && rdata_oe === 1'b1) begin
      data = rdata;
    end
    @(negedge sys_clk);
    bus_in = '{cs_n: 1'b1, ds_n: 1'b1, read_not_write: 1'b1, iack_n: 1'b1, addr: ~addr, wdata: ~wdata};
    @(negedge sys_clk);
  endtask
endmodule // serial_parallel_host_model

// File: verification/test_serial_parallel_mode1_regs.sv
// self-checking bench for the mode 1 register bank
module test_serial_parallel_mode1_regs;
  timeunit 1ns;
  timeprecision 1ps;
  import serial_parallel_pkg::*;
  logic sys_clk;
  logic rst_n;
  bus_in_s bus_in;
  logic [7:0] rdata;
  logic rdata_oe;
  logic dtack_n;
  logic irq_n;
  ram_wr_s rx_wr;
  logic [4:0] tx_rd_chan;
  logic [7:0] tx0_rd_data;
  logic [7:0] tx1_rd_data;
  path_event_s path1_event;
  path_event_s path2_event;
  path_cfg_s path1_cfg;
  path_cfg_s path2_cfg;
  logic ram_size_select;
  logic [3:0] loop_output_config;
  int n_fail = 0;
  int n_tests = 0;
  logic [7:0] d;
  logic [7:0] t0;
  logic [7:0] t1;
  serial_parallel_mode1_regs i_dut (.sys_clk(sys_clk), .rst_n(rst_n), .bus_in(bus_in), .rdata(rdata),
    .rdata_oe(rdata_oe), .dtack_n(dtack_n), .irq_n(irq_n), .rx_wr(rx_wr), .tx_rd_chan(tx_rd_chan),
    .tx0_rd_data(tx0_rd_data), .tx1_rd_data(tx1_rd_data), .path1_event(path1_event),
    .path2_event(path2_event), .path1_cfg(path1_cfg), .path2_cfg(path2_cfg),
    .ram_size_select(ram_size_select), .loop_output_config(loop_output_config));
  serial_parallel_host_model i_host (.sys_clk(sys_clk), .dtack_n(dtack_n), .rdata(rdata),
    .rdata_oe(rdata_oe), .bus_in(bus_in));
  // free-running clock
  initial begin
    sys_clk = 1'b0;
    forever #4 sys_clk = ~sys_clk;
  end
  // ----------------------------------------
  // helpers
  // ----------------------------------------
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  task automatic cmp8(input logic [7:0] got, input logic [7:0] exp);
    n_tests++;
    if (got !== exp) begin
      n_fail++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic cmp1(input logic got, input logic exp);
    cmp8({7'h00, got}, {7'h00, exp});
  endtask
  task automatic bus(input logic iack, input logic rnw, input logic [5:0] a, input logic [7:0] w,
                     output logic [7:0] r);
    logic ok;
    i_host.access(iack, rnw, a, w, r, ok);
    if (!ok) begin
      n_fail++;
      print_verdict();
    end
  endtask
  task automatic wr(input logic [5:0] a, input logic [7:0] w);
    logic [7:0] r;
    bus(1'b0, 1'b0, a, w, r);
  endtask
  task automatic rd(input logic [5:0] a, output logic [7:0] r);
    bus(1'b0, 1'b1, a, 8'h00, r);
  endtask
  task automatic rx_put(input logic [4:0] c, input logic [7:0] v);
    @(negedge sys_clk);
    rx_wr = '{en: 1'b1, chan: c, data: v};
    @(negedge sys_clk);
    rx_wr.en = 1'b0;
  endtask
  task automatic tx_peek(input logic [4:0] c, output logic [7:0] v0, output logic [7:0] v1);
    @(negedge sys_clk);
    tx_rd_chan = c;
    @(negedge sys_clk);
    v0 = tx0_rd_data;
    v1 = tx1_rd_data;
  endtask
  task automatic hit(input logic p2, input logic [7:0] f, input logic [7:0] img);
    @(negedge sys_clk);
    if (p2) path2_event = '{hit: 1'b1, flags: f, image: img};
    else path1_event = '{hit: 1'b1, flags: f, image: img};
    @(negedge sys_clk);
    path1_event.hit = 1'b0;
    path2_event.hit = 1'b0;
    @(negedge sys_clk);
  endtask
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_reset();
    rd(ADDR_MAIN_CONTROL, d);
    cmp8(d, 8'h00);
    cmp1(path1_cfg.enable | path2_cfg.enable | ram_size_select, 1'b0);
    cmp1(irq_n, 1'b1);
  endtask
  task automatic t_channel_ram();
    rx_put(5'h00, 8'ha5);
    rx_put(5'h1f, 8'h5a);
    wr(6'h00, 8'h11);
    wr(6'h1f, 8'h22);
    wr(6'h18, 8'h44);
    rd(6'h00, d);
    cmp8(d, 8'ha5);
    rd(6'h1f, d);
    cmp8(d, 8'h5a);
    tx_peek(5'h00, t0, t1);
    cmp8(t0, 8'h11);
    tx_peek(5'h1f, t0, t1);
    cmp8(t0, 8'h22);
  endtask
  task automatic t_page();
    wr(ADDR_MAIN_CONTROL, 8'h10);
    wr(6'h1f, 8'h33);
    tx_peek(5'h1f, t0, t1);
    cmp8(t0, 8'h22);
    cmp8(t1, 8'h33);
    rd(6'h1f, d);
    cmp8(d, 8'h5a);
    wr(ADDR_MAIN_CONTROL, 8'h00);
  endtask
  task automatic t_rw_and_readonly();
    for (int i = 0; i < 6; i++) wr(ADDR_P1_MASK + 6'(i), 8'h81 + 8'(i));
    for (int i = 0; i < 4; i++) wr(ADDR_P1_FLAGS + 6'(i), 8'hff);
    wr(6'h2e, 8'hff);
    wr(6'h23, 8'hff);
    wr(ADDR_LOOP_OUTPUT, 8'hf9);
    rd(ADDR_LOOP_OUTPUT, d);
    cmp8(d, 8'h09);
    cmp8({4'h0, loop_output_config}, 8'h09);
    for (int i = 0; i < 6; i++) begin
      rd(ADDR_P1_MASK + 6'(i), d);
      cmp8(d, 8'h81 + 8'(i));
    end
    for (int i = 0; i < 4; i++) begin
      rd(ADDR_P1_FLAGS + 6'(i), d);
      cmp8(d, 8'h00);
    end
    cmp8(path1_cfg.mask, 8'h81);
    cmp8(path2_cfg.compare, 8'h84);
    cmp8(path2_cfg.channel, 8'h86);
  endtask
  task automatic t_events();
    wr(ADDR_VECTOR, 8'ha7);
    hit(1'b0, 8'h02, 8'h55);
    cmp1(irq_n, 1'b1);
    wr(ADDR_MAIN_CONTROL, 8'h01);
    hit(1'b1, 8'h01, 8'h77);
    cmp1(irq_n, 1'b1);
    rd(ADDR_P2_IMAGE, d);
    cmp8(d, 8'h00);
    hit(1'b0, 8'h01, 8'h3c);
    cmp1(irq_n, 1'b0);
    bus(1'b1, 1'b1, 6'h00, 8'h00, d);
    cmp8(d, 8'ha5);
    rd(ADDR_VECTOR, d);
    cmp8(d, 8'ha5);
    rd(ADDR_P1_IMAGE, d);
    cmp8(d, 8'h3c);
    rd(ADDR_P1_IMAGE, d);
    cmp8(d, 8'h00);
    rd(ADDR_P1_FLAGS, d);
    cmp8(d, 8'h01);
  endtask
  task automatic t_clear();
    wr(ADDR_MAIN_CONTROL, 8'h03);
    hit(1'b1, 8'h80, 8'hc3);
    cmp1(irq_n, 1'b0);
    wr(ADDR_MAIN_CONTROL, 8'h43);
    rd(ADDR_MAIN_CONTROL, d);
    cmp8(d, 8'h03);
    rd(ADDR_P2_FLAGS, d);
    cmp8(d, 8'h00);
    rd(ADDR_P2_IMAGE, d);
    cmp8(d, 8'h00);
    cmp1(irq_n, 1'b1);
  endtask
  task automatic t_size_kind();
    rx_put(5'h19, 8'h66);
    wr(ADDR_MAIN_CONTROL, 8'h2c);
    cmp1(ram_size_select, 1'b1);
    cmp1(path1_cfg.kind, 1'b1);
    cmp1(path2_cfg.kind, 1'b1);
    wr(6'h18, 8'h99);
    tx_peek(5'h18, t0, t1);
    cmp8(t0, 8'h44);
    rd(6'h19, d);
    cmp8(d, 8'h00);
    wr(ADDR_MAIN_CONTROL, 8'h04);
    cmp1(path1_cfg.kind, 1'b1);
    cmp1(path2_cfg.kind, 1'b0);
    cmp1(ram_size_select, 1'b0);
  endtask
  // main sequence: reset for 16 cycles, then the scenarios
  initial begin
    rst_n = 1'b0;
    rx_wr = '{en: 1'b0, chan: 5'h00, data: 8'h00};
    tx_rd_chan = 5'h00;
    path1_event = '{hit: 1'b0, flags: 8'h00, image: 8'h00};
    path2_event = '{hit: 1'b0, flags: 8'h00, image: 8'h00};
    repeat (16) @(negedge sys_clk);
    rst_n = 1'b1;
    t_reset();
    t_channel_ram();
    t_page();
    t_rw_and_readonly();
    t_events();
    t_clear();
    t_size_kind();
    print_verdict();
  end
endmodule // test_serial_parallel_mode1_regs
